// *** core/acl_defines.vh ***
// Constants for the audio configuration and serial link status registers.
// Assumes inclusion by bare name from files under core/.
`ifndef ACL_DEFINES_VH
`define ACL_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ACL_OFF_AUDIO_CONFIG 8'h55
`define ACL_OFF_LINK_STATUS 8'h5a

// ----------------------------------------------------------------
// Reset values and configuration write mask
// ----------------------------------------------------------------
`define ACL_RST_AUDIO_CONFIG 8'h0c
`define ACL_RST_LINK_STATUS 8'h00
`define ACL_CFG_WRITE_MASK 8'hcf

// ----------------------------------------------------------------
// Audio configuration fields
// ----------------------------------------------------------------
`define ACL_CFG_TDM_CONV 7
`define ACL_CFG_HDMI_I2S_OUT 6
`define ACL_CFG_CLR_ON_TYPE 3
`define ACL_CFG_CLR_ON_AIF 2
`define ACL_CFG_CLR_ON_AVI 1
`define ACL_CFG_CLR_ON_ACR 0

// ----------------------------------------------------------------
// Link status fields
// ----------------------------------------------------------------
`define ACL_STS_LINK_READY 7
`define ACL_STS_TX_LOCKED 6
`define ACL_STS_PORT_HI 5
`define ACL_STS_PORT_LO 4
`define ACL_STS_SYMBOLS 3
`define ACL_STS_PLL_LOCK 2
`define ACL_STS_NO_CLOCK 1
`define ACL_STS_FREQ_SETTLED 0
`define ACL_PORT_NONE 2'h0
`define ACL_PORT_SINGLE_P0 2'h1

// ----------------------------------------------------------------
// Audio source selection and serial port
// ----------------------------------------------------------------
`define ACL_SRC_HDMI 1'h0
`define ACL_SRC_LOCAL 1'h1
// Arbitrary value
`define ACL_I2C_ADDR 7'h2c

// ----------------------------------------------------------------
// Packet field widths
// ----------------------------------------------------------------
`define ACL_W_TYPE 8
`define ACL_W_CSUM 8
`define ACL_W_ACR 40

`endif

// *** core/acl_change_det.v ***
// Change detector for one received packet field.
// Assumes the field is synchronous to sys_clk; the first value after reset primes it.
`timescale 1ns/1ps

module acl_change_det #(
  parameter WIDTH = 8
) (
  input wire sys_clk,
  input wire rst,
  input wire [WIDTH-1:0] field_in,
  output reg changed
);

  reg [WIDTH-1:0] last_reg;
  reg primed_reg;

  // ----------------------------------------------------------------
  // Compare against the previous sample
  // ----------------------------------------------------------------
  // Priming avoids a spurious clear on the first value seen after reset
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_reg <= {WIDTH{1'b0}};
      primed_reg <= 1'b0;
      changed <= 1'b0;
    end else begin
      last_reg <= field_in;
      primed_reg <= 1'b1;
      changed <= primed_reg && (field_in != last_reg);
    end
  end

endmodule // acl_change_det

// *** core/acl_regs.v ***
// Audio configuration and serial link status registers with their I2C slave port.
// Assumes all inputs, SCL and SDA included, are synchronous to sys_clk.
`timescale 1ns/1ps
`include "acl_defines.vh"

// Operation
// - Config bit 7 enables TDM-to-parallel conversion
// - Conversion clock feeds downstream audio when enabled
// - Config bit 6 drives HDMI audio on I2S pins
// - HDMI I2S output only when source is HDMI
// - Bit 3: clear audio FIFO on type change
// - Bit 2: clear FIFO on audio infoframe checksum change
// - Bit 1: clear FIFO on video infoframe checksum change
// - Bit 0: clear FIFO on N/CTS change
// - Status bit 7: downstream link ready
// - Status bit 6: transmitter active, receiver locked
// - Tx bit held clear until input and mode valid
// - Bits 5:4 report port mode when locked
// - Bit 3 symbols recovered; early revision reads one
// - Bit 2 shows receive PLL locked
// - Bit 1 shows no clock above threshold
// - Bit 0 shows input frequency settled
// - Source select: zero HDMI, one local I2S
module acl_regs #(
  parameter EARLY_REV = 0
) (
  input wire sys_clk,
  input wire rst,
  input wire i2c_scl,
  input wire i2c_sda_in,
  output reg i2c_sda_out,
  output reg i2c_sda_oe_n,
  input wire audio_source_sel,
  input wire hdmi_aud_sck,
  input wire hdmi_aud_ws,
  input wire hdmi_aud_sd,
  input wire local_aud_sck,
  input wire local_aud_ws,
  input wire local_aud_sd,
  input wire tdm_conv_clk,
  input wire [`ACL_W_TYPE-1:0] audio_type,
  input wire [`ACL_W_CSUM-1:0] audio_infoframe_csum,
  input wire [`ACL_W_CSUM-1:0] video_infoframe_csum,
  input wire [`ACL_W_ACR-1:0] clock_regen_n_cts,
  input wire downstream_link_ready,
  input wire serial_tx_active,
  input wire remote_rx_locked,
  input wire valid_input_seen,
  input wire serial_mode_correct,
  input wire [1:0] serial_port_mode,
  input wire input_symbols_recovered,
  input wire rx_pll_locked,
  input wire below_min_input_freq,
  input wire input_frequency_settled,
  output reg tdm_conv_en,
  output reg ds_aud_clk,
  output reg ds_aud_ws,
  output reg ds_aud_sd,
  output reg i2s_pins_out_en,
  output reg i2s_sck_out,
  output reg i2s_ws_out,
  output reg i2s_sd_out,
  output reg audio_fifo_clear
);

  // ----------------------------------------------------------------
  // I2C slave states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 4'h0;
  localparam ST_ADDR = 4'h1;
  localparam ST_ADDR_ACK = 4'h2;
  localparam ST_PTR = 4'h3;
  localparam ST_PTR_ACK = 4'h4;
  localparam ST_WDATA = 4'h5;
  localparam ST_WDATA_ACK = 4'h6;
  localparam ST_RDATA = 4'h7;
  localparam ST_RDATA_ACK = 4'h8;

  reg [3:0] state_reg;
  reg scl_prev_reg;
  reg sda_prev_reg;
  reg [7:0] rx_shift_reg;
  reg [7:0] tx_shift_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] ptr_reg;
  reg is_read_reg;
  reg master_ack_reg;
  reg [7:0] audio_config_reg;
  reg [7:0] link_status_reg;
  reg [7:0] link_status_next;
  reg [7:0] read_data;
  reg cfg_write;
  reg [7:0] fifo_clr_cause;

  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire type_changed;
  wire aif_changed;
  wire avi_changed;
  wire acr_changed;
  wire tx_locked;
  wire hdmi_i2s_allowed;

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  assign scl_rise = i2c_scl && !scl_prev_reg;
  assign scl_fall = !i2c_scl && scl_prev_reg;
  assign bus_start = i2c_scl && scl_prev_reg && sda_prev_reg && !i2c_sda_in;
  assign bus_stop = i2c_scl && scl_prev_reg && !sda_prev_reg && i2c_sda_in;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= i2c_scl;
      sda_prev_reg <= i2c_sda_in;
    end
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero
  always @* begin
    case (ptr_reg)
      `ACL_OFF_AUDIO_CONFIG: read_data = audio_config_reg & `ACL_CFG_WRITE_MASK;
      `ACL_OFF_LINK_STATUS: read_data = link_status_reg;
      default: read_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // I2C slave engine
  // ----------------------------------------------------------------
  // Software on the external controller owns all accesses
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      ptr_reg <= 8'h00;
      is_read_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      i2c_sda_oe_n <= 1'b1;
      i2c_sda_out <= 1'b0;
      cfg_write <= 1'b0;
    end else begin
      cfg_write <= 1'b0;
      i2c_sda_out <= 1'b0;
      if (bus_start) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        i2c_sda_oe_n <= 1'b1;
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        i2c_sda_oe_n <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            i2c_sda_oe_n <= 1'b1;
          end
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (scl_rise && bit_cnt_reg != 4'h8) begin
              rx_shift_reg <= {rx_shift_reg[6:0], i2c_sda_in};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (rx_shift_reg[7:1] == `ACL_I2C_ADDR) begin
                  is_read_reg <= rx_shift_reg[0];
                  i2c_sda_oe_n <= 1'b0;
                  state_reg <= ST_ADDR_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else if (state_reg == ST_PTR) begin
                ptr_reg <= rx_shift_reg;
                i2c_sda_oe_n <= 1'b0;
                state_reg <= ST_PTR_ACK;
              end else begin
                // Writes to the status offset fall through and are lost
                cfg_write <= (ptr_reg == `ACL_OFF_AUDIO_CONFIG);
                i2c_sda_oe_n <= 1'b0;
                state_reg <= ST_WDATA_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (is_read_reg) begin
                tx_shift_reg <= read_data;
                i2c_sda_oe_n <= read_data[7];
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_RDATA;
              end else begin
                i2c_sda_oe_n <= 1'b1;
                state_reg <= ST_PTR;
              end
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              i2c_sda_oe_n <= 1'b1;
              if (state_reg == ST_WDATA_ACK) begin
                ptr_reg <= ptr_reg + 8'h01;
              end
              state_reg <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                i2c_sda_oe_n <= 1'b1;
                bit_cnt_reg <= 4'h0;
                state_reg <= ST_RDATA_ACK;
              end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                i2c_sda_oe_n <= tx_shift_reg[6];
              end
            end
          end
          ST_RDATA_ACK: begin
            if (scl_rise) begin
              master_ack_reg <= !i2c_sda_in;
            end else if (scl_fall) begin
              if (master_ack_reg) begin
                tx_shift_reg <= read_data;
                i2c_sda_oe_n <= read_data[7];
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_RDATA;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            i2c_sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Audio configuration register
  // ----------------------------------------------------------------
  // The write lands one cycle after the data byte completes
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      audio_config_reg <= `ACL_RST_AUDIO_CONFIG;
    end else if (cfg_write) begin
      audio_config_reg <= rx_shift_reg & `ACL_CFG_WRITE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Link status register
  // ----------------------------------------------------------------
  assign tx_locked = serial_tx_active && remote_rx_locked &&
                     valid_input_seen && serial_mode_correct;

  always @* begin
    link_status_next = `ACL_RST_LINK_STATUS;
    link_status_next[`ACL_STS_LINK_READY] = downstream_link_ready;
    link_status_next[`ACL_STS_TX_LOCKED] = tx_locked;
    // Port field is meaningless while the transmitter is not locked
    link_status_next[`ACL_STS_PORT_HI:`ACL_STS_PORT_LO] =
      tx_locked ? serial_port_mode : `ACL_PORT_NONE;
    link_status_next[`ACL_STS_SYMBOLS] =
      (EARLY_REV != 0) ? 1'b1 : input_symbols_recovered;
    link_status_next[`ACL_STS_PLL_LOCK] = rx_pll_locked;
    link_status_next[`ACL_STS_NO_CLOCK] = below_min_input_freq;
    link_status_next[`ACL_STS_FREQ_SETTLED] = input_frequency_settled;
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      link_status_reg <= `ACL_RST_LINK_STATUS;
    end else begin
      link_status_reg <= link_status_next;
    end
  end

  // ----------------------------------------------------------------
  // Audio FIFO clear on packet changes
  // ----------------------------------------------------------------
  acl_change_det #(.WIDTH(`ACL_W_TYPE)) u_type_det (
    .sys_clk(sys_clk),
    .rst(rst),
    .field_in(audio_type),
    .changed(type_changed)
  );

  acl_change_det #(.WIDTH(`ACL_W_CSUM)) u_aif_det (
    .sys_clk(sys_clk),
    .rst(rst),
    .field_in(audio_infoframe_csum),
    .changed(aif_changed)
  );

  acl_change_det #(.WIDTH(`ACL_W_CSUM)) u_avi_det (
    .sys_clk(sys_clk),
    .rst(rst),
    .field_in(video_infoframe_csum),
    .changed(avi_changed)
  );

  acl_change_det #(.WIDTH(`ACL_W_ACR)) u_acr_det (
    .sys_clk(sys_clk),
    .rst(rst),
    .field_in(clock_regen_n_cts),
    .changed(acr_changed)
  );

  always @* begin
    fifo_clr_cause = 8'h00;
    fifo_clr_cause[`ACL_CFG_CLR_ON_TYPE] = type_changed;
    fifo_clr_cause[`ACL_CFG_CLR_ON_AIF] = aif_changed;
    fifo_clr_cause[`ACL_CFG_CLR_ON_AVI] = avi_changed;
    fifo_clr_cause[`ACL_CFG_CLR_ON_ACR] = acr_changed;
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      audio_fifo_clear <= 1'b0;
    end else begin
      audio_fifo_clear <= |(fifo_clr_cause & audio_config_reg);
    end
  end

  // ----------------------------------------------------------------
  // Audio routing
  // ----------------------------------------------------------------
  assign hdmi_i2s_allowed = (audio_source_sel == `ACL_SRC_HDMI);

  // Clocks are treated as sampled data here, so edges are sys_clk quantised
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tdm_conv_en <= 1'b0;
      ds_aud_clk <= 1'b0;
      ds_aud_ws <= 1'b0;
      ds_aud_sd <= 1'b0;
      i2s_pins_out_en <= 1'b0;
      i2s_sck_out <= 1'b0;
      i2s_ws_out <= 1'b0;
      i2s_sd_out <= 1'b0;
    end else begin
      tdm_conv_en <= audio_config_reg[`ACL_CFG_TDM_CONV];
      if (audio_source_sel == `ACL_SRC_LOCAL) begin
        ds_aud_clk <= local_aud_sck;
        ds_aud_ws <= local_aud_ws;
        ds_aud_sd <= local_aud_sd;
      end else begin
        ds_aud_clk <= hdmi_aud_sck;
        ds_aud_ws <= hdmi_aud_ws;
        ds_aud_sd <= hdmi_aud_sd;
      end
      if (audio_config_reg[`ACL_CFG_TDM_CONV]) begin
        ds_aud_clk <= tdm_conv_clk;
      end
      i2s_pins_out_en <= audio_config_reg[`ACL_CFG_HDMI_I2S_OUT] && hdmi_i2s_allowed;
      if (audio_config_reg[`ACL_CFG_HDMI_I2S_OUT] && hdmi_i2s_allowed) begin
        i2s_sck_out <= hdmi_aud_sck;
        i2s_ws_out <= hdmi_aud_ws;
        i2s_sd_out <= hdmi_aud_sd;
      end else begin
        i2s_sck_out <= 1'b0;
        i2s_ws_out <= 1'b0;
        i2s_sd_out <= 1'b0;
      end
    end
  end

endmodule // acl_regs

// *** verification/acl_regs_chk.sv ***
// Port-level checks for the audio config and link status register block.
// Assumes acl_defines.vh is on the include path; bound to every acl_regs.
`timescale 1ns/1ps
`include "acl_defines.vh"

module acl_regs_chk (
  input wire sys_clk,
  input wire rst,
  input wire i2c_scl,
  input wire i2c_sda_out,
  input wire i2c_sda_oe_n,
  input wire audio_source_sel,
  input wire hdmi_aud_sck,
  input wire hdmi_aud_sd,
  input wire local_aud_sck,
  input wire local_aud_sd,
  input wire tdm_conv_clk,
  input wire [`ACL_W_TYPE-1:0] audio_type,
  input wire [`ACL_W_CSUM-1:0] audio_infoframe_csum,
  input wire [`ACL_W_CSUM-1:0] video_infoframe_csum,
  input wire [`ACL_W_ACR-1:0] clock_regen_n_cts,
  input wire tdm_conv_en,
  input wire ds_aud_clk,
  input wire ds_aud_sd,
  input wire i2s_pins_out_en,
  input wire i2s_sd_out,
  input wire audio_fifo_clear
);
  // --------------------
  // Helper logic
  // --------------------
  // Change history spans four cycles so detector latency is not pinned too tightly
  reg [1:0] age_reg;
  reg [63:0] fld_reg;
  reg [3:0] chg_reg;
  wire [63:0] fld = {audio_type, audio_infoframe_csum, video_infoframe_csum, clock_regen_n_cts};
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      age_reg <= 2'h0;
      fld_reg <= 64'h0;
      chg_reg <= 4'h0;
    end else begin
      age_reg <= (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
      fld_reg <= fld;
      chg_reg <= {chg_reg[2:0], fld != fld_reg};
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // --------------------
  // Assertions
  // --------------------
  a_tdm_clk_path: assert property (
    age_reg == 2'h3 && tdm_conv_en && $past(tdm_conv_en) |-> ds_aud_clk == $past(tdm_conv_clk))
    else $error("Converter clock not sent downstream");
  a_src_clk_path: assert property (
    age_reg == 2'h3 && !tdm_conv_en && !$past(tdm_conv_en)
    |-> ds_aud_clk == ($past(audio_source_sel) ? $past(local_aud_sck) : $past(hdmi_aud_sck)))
    else $error("Downstream clock from wrong source");
  a_src_data_path: assert property (
    age_reg == 2'h3
    |-> ds_aud_sd == ($past(audio_source_sel) ? $past(local_aud_sd) : $past(hdmi_aud_sd)))
    else $error("Downstream data from wrong source");
  a_pins_need_hdmi: assert property (
    i2s_pins_out_en |-> $past(audio_source_sel) == 1'b0)
    else $error("Audio pins enabled with local source");
  a_pins_carry_hdmi: assert property (
    age_reg == 2'h3 && i2s_pins_out_en |-> i2s_sd_out == $past(hdmi_aud_sd))
    else $error("Audio pins not carrying input audio");
  a_pins_quiet_off: assert property (
    !i2s_pins_out_en |-> i2s_sd_out == 1'b0)
    else $error("Audio pin data while disabled");
  a_clear_has_cause: assert property (
    audio_fifo_clear |-> chg_reg != 4'h0)
    else $error("FIFO clear without field change");
  a_sda_low_only: assert property (
    !i2c_sda_oe_n |-> i2c_sda_out == 1'b0)
    else $error("Data line driven high");
  a_sda_moves_scl_low: assert property (
    $changed(i2c_sda_oe_n) |-> !i2c_scl)
    else $error("Data line moved while clock high");
  c_fifo_clear: cover property (audio_fifo_clear);
  c_ack: cover property ($fell(i2c_sda_oe_n));
  c_pins: cover property (i2s_pins_out_en && i2s_sd_out);
endmodule // acl_regs_chk

bind acl_regs acl_regs_chk acl_regs_chk_inst (
  .sys_clk(sys_clk), .rst(rst), .i2c_scl(i2c_scl), .i2c_sda_out(i2c_sda_out),
  .i2c_sda_oe_n(i2c_sda_oe_n), .audio_source_sel(audio_source_sel),
  .hdmi_aud_sck(hdmi_aud_sck), .hdmi_aud_sd(hdmi_aud_sd), .local_aud_sck(local_aud_sck),
  .local_aud_sd(local_aud_sd), .tdm_conv_clk(tdm_conv_clk), .audio_type(audio_type),
  .audio_infoframe_csum(audio_infoframe_csum), .video_infoframe_csum(video_infoframe_csum),
  .clock_regen_n_cts(clock_regen_n_cts), .tdm_conv_en(tdm_conv_en),
  .ds_aud_clk(ds_aud_clk), .ds_aud_sd(ds_aud_sd), .i2s_pins_out_en(i2s_pins_out_en),
  .i2s_sd_out(i2s_sd_out), .audio_fifo_clear(audio_fifo_clear)
);

// *** verification/tb_acl_regs.sv ***
// Self-checking bench for the audio config and link status register block.
// Assumes acl_regs and its bound checker are compiled; acl_defines.vh on the include path.
`timescale 1ns/1ps
`include "acl_defines.vh"

module tb_acl_regs;
  // --------------------
  // Signals
  // --------------------
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg i2c_scl = 1'b1;
  reg msda = 1'b1;
  reg audio_source_sel = 1'b0;
  reg [3:0] cnt = 4'h0;
  reg [10:0] sts = 11'h000;
  reg [7:0] audio_type = 8'h00;
  reg [7:0] audio_infoframe_csum = 8'h00;
  reg [7:0] video_infoframe_csum = 8'h00;
  reg [39:0] clock_regen_n_cts = 40'h0;
  integer err_count = 0;
  integer compares = 0;
  integer i, n;
  reg [7:0] d;
  reg [7:0] p;
  localparam [43:0] SP = {11'h359, 11'h792, 11'h7df, 11'h000};
  localparam [31:0] SE = {8'h09, 8'h82, 8'hdf, 8'h00};
  wire i2c_sda_out, i2c_sda_oe_n, tdm_conv_en, ds_aud_clk, ds_aud_sd;
  wire i2s_pins_out_en, i2s_sd_out, audio_fifo_clear;
  wire ds_aud_ws, i2s_sck_out, i2s_ws_out;
  wire i2c_sda_in = msda & (i2c_sda_oe_n | i2c_sda_out);
  wire downstream_link_ready, serial_tx_active, remote_rx_locked, valid_input_seen;
  wire serial_mode_correct, input_symbols_recovered, rx_pll_locked;
  wire below_min_input_freq, input_frequency_settled;
  wire [1:0] serial_port_mode;
  assign {downstream_link_ready, serial_tx_active, remote_rx_locked, valid_input_seen,
    serial_mode_correct, serial_port_mode, input_symbols_recovered, rx_pll_locked,
    below_min_input_freq, input_frequency_settled} = sts;
  // Distinct patterns per source so a wrong mux leg shows within a few samples
  wire hdmi_aud_sck = cnt[0];
  wire hdmi_aud_ws = cnt[3];
  wire hdmi_aud_sd = cnt[1];
  wire local_aud_sck = ~cnt[0];
  wire local_aud_ws = cnt[2];
  wire local_aud_sd = cnt[2] ^ cnt[0];
  wire tdm_conv_clk = cnt[1] ^ cnt[3];

  acl_regs acl_regs_inst (
    .sys_clk(sys_clk), .rst(rst), .i2c_scl(i2c_scl), .i2c_sda_in(i2c_sda_in),
    .i2c_sda_out(i2c_sda_out), .i2c_sda_oe_n(i2c_sda_oe_n), .audio_source_sel(audio_source_sel),
    .hdmi_aud_sck(hdmi_aud_sck), .hdmi_aud_ws(hdmi_aud_ws), .hdmi_aud_sd(hdmi_aud_sd),
    .local_aud_sck(local_aud_sck), .local_aud_ws(local_aud_ws), .local_aud_sd(local_aud_sd),
    .tdm_conv_clk(tdm_conv_clk), .audio_type(audio_type),
    .audio_infoframe_csum(audio_infoframe_csum), .video_infoframe_csum(video_infoframe_csum),
    .clock_regen_n_cts(clock_regen_n_cts), .downstream_link_ready(downstream_link_ready),
    .serial_tx_active(serial_tx_active), .remote_rx_locked(remote_rx_locked),
    .valid_input_seen(valid_input_seen), .serial_mode_correct(serial_mode_correct),
    .serial_port_mode(serial_port_mode), .input_symbols_recovered(input_symbols_recovered),
    .rx_pll_locked(rx_pll_locked), .below_min_input_freq(below_min_input_freq),
    .input_frequency_settled(input_frequency_settled), .tdm_conv_en(tdm_conv_en),
    .ds_aud_clk(ds_aud_clk), .ds_aud_ws(ds_aud_ws), .ds_aud_sd(ds_aud_sd),
    .i2s_pins_out_en(i2s_pins_out_en), .i2s_sck_out(i2s_sck_out), .i2s_ws_out(i2s_ws_out),
    .i2s_sd_out(i2s_sd_out),
    .audio_fifo_clear(audio_fifo_clear)
  );

  initial forever #4 sys_clk = ~sys_clk;
  initial forever begin
    @(posedge sys_clk);
    #1 cnt = cnt + 4'h1;
  end

  // --------------------
  // Tasks
  // --------------------
  task chk(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("Mismatches %0d, comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Four clocks per bus phase keeps margin over the two-sample minimum
  task step;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task xb(input b, output r);
    msda = b;
    step;
    i2c_scl = 1'b1;
    step;
    r = i2c_sda_in;
    i2c_scl = 1'b0;
    step;
  endtask
  task xbyte(input [7:0] v, output [7:0] q);
    integer k;
    reg r;
    for (k = 7; k >= 0; k = k - 1) begin
      xb(v[k], r);
      q = {q[6:0], r};
    end
  endtask
  task start;
    step;
    msda = 1'b1;
    step;
    i2c_scl = 1'b1;
    step;
    msda = 1'b0;
    step;
    i2c_scl = 1'b0;
    step;
  endtask
  task stop;
    msda = 1'b0;
    step;
    i2c_scl = 1'b1;
    step;
    msda = 1'b1;
    step;
  endtask
  task sendb(input [7:0] v);
    reg [7:0] q;
    reg a;
    xbyte(v, q);
    xb(1'b1, a);
    chk({7'h0, a}, 8'h00);
  endtask
  task wr(input [7:0] a, input [7:0] v);
    start;
    sendb({`ACL_I2C_ADDR, 1'b0});
    sendb(a);
    sendb(v);
    stop;
  endtask
  task rd(input [7:0] a, output [7:0] v);
    reg k;
    start;
    sendb({`ACL_I2C_ADDR, 1'b0});
    sendb(a);
    start;
    sendb({`ACL_I2C_ADDR, 1'b1});
    xbyte(8'hff, v);
    xb(1'b1, k);
    stop;
  endtask
  task snap(output [7:0] q);
    @(posedge sys_clk);
    q = {1'b0, local_aud_sck, local_aud_ws, hdmi_aud_ws, hdmi_aud_sck, tdm_conv_clk,
      local_aud_sd, hdmi_aud_sd};
    @(negedge sys_clk);
  endtask
  task bump(input integer k, output integer c);
    case (k)
      0: clock_regen_n_cts = clock_regen_n_cts + 40'h1;
      1: video_infoframe_csum = video_infoframe_csum + 8'h1;
      2: audio_infoframe_csum = audio_infoframe_csum + 8'h1;
      default: audio_type = audio_type + 8'h1;
    endcase
    c = 0;
    repeat (6) begin
      @(negedge sys_clk);
      if (audio_fifo_clear === 1'b1) c = c + 1;
    end
    step;
  endtask

  // --------------------
  // Tests
  // --------------------
  initial begin
    #500000;
    err_count = err_count + 1;
    test_done;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    rd(8'h55, d);
    chk(d, 8'h0c);
    wr(8'h55, 8'hff);
    rd(8'h55, d);
    chk(d, 8'hcf);
    chk({7'h0, tdm_conv_en}, 8'h01);
    start;
    xbyte(8'h5a, d);
    xb(1'b1, p[0]);
    stop;
    chk({7'h0, p[0]}, 8'h01);
    rd(8'h10, d);
    chk(d, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      sts = SP[i*11 +: 11];
      rd(8'h5a, d);
      chk(d, SE[i*8 +: 8]);
    end
    wr(8'h5a, 8'hff);
    rd(8'h5a, d);
    chk(d, 8'h09);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h55, 8'h01 << i);
      bump((i + 1) % 4, n);
      chk(n[7:0], 8'h00);
      bump(i, n);
      chk(n[7:0], 8'h01);
    end
    wr(8'h55, 8'h40);
    repeat (6) begin
      snap(p);
      chk({7'h0, i2s_pins_out_en}, 8'h01);
      chk({7'h0, i2s_sd_out}, {7'h0, p[0]});
      chk({7'h0, ds_aud_sd}, {7'h0, p[0]});
      chk({6'h0, ds_aud_clk, ds_aud_ws}, {6'h0, p[3], p[4]});
      chk({6'h0, i2s_sck_out, i2s_ws_out}, {6'h0, p[3], p[4]});
    end
    step;
    audio_source_sel = 1'b1;
    step;
    repeat (6) begin
      snap(p);
      chk({7'h0, i2s_pins_out_en}, 8'h00);
      chk({7'h0, ds_aud_sd}, {7'h0, p[1]});
      chk({6'h0, ds_aud_clk, ds_aud_ws}, {6'h0, p[6], p[5]});
      chk({6'h0, i2s_sck_out, i2s_ws_out}, 8'h00);
    end
    wr(8'h55, 8'h80);
    repeat (6) begin
      snap(p);
      chk({7'h0, ds_aud_clk}, {7'h0, p[2]});
    end
    test_done;
  end
endmodule // tb_acl_regs
